// ### hdl/rhx_pkg.sv
// Package: constants and types of the exclusive-control block
package rhx_pkg;
  // ==========================================================
  // Host command codes
  localparam logic [7:0] CMD_READ = 8'h06;
  localparam logic [7:0] CMD_WRITE = 8'h08;
  localparam logic [7:0] CMD_STATUS = 8'h0A;
  localparam logic [7:0] CMD_REG_WR = 8'h0C;
  localparam logic [7:0] CMD_REG_RD = 8'h0E;
  localparam logic [7:0] CMD_QUERY = 8'h28;
  localparam logic [7:0] CMD_ANS_OK = 8'hF8;
  localparam logic [7:0] CMD_ANS_ERR = 8'hE8;
  // ==========================================================
  // Host response status codes
  localparam logic [7:0] ST_NORMAL = 8'h00;
  localparam logic [7:0] ST_BUSY = 8'h01;
  localparam logic [7:0] ST_HOST_BUSY = 8'h02;
  localparam logic [7:0] ST_UNIMPL = 8'h03;
  localparam logic [7:0] ST_TUN_ERR = 8'h04;
  localparam logic [7:0] ST_TUN_RD = 8'h05;
  localparam logic [7:0] ST_TUN_WR = 8'h06;
  localparam logic [7:0] ST_DIAG = 8'h07;
  localparam logic [7:0] ST_QUERY_OK = 8'h08;
  // ==========================================================
  // RF reply kinds
  localparam logic [1:0] RPL_NONE = 2'h0;
  localparam logic [1:0] RPL_NORMAL = 2'h1;
  localparam logic [1:0] RPL_WTX = 2'h2;
  localparam logic [1:0] RPL_TUNNEL = 2'h3;
  // ==========================================================
  // Events RF side to host side, and back
  localparam logic [1:0] EV_OP_START = 2'h0;
  localparam logic [1:0] EV_OP_END = 2'h1;
  localparam logic [1:0] EV_TUN = 2'h2;
  localparam logic [1:0] DN_ANS_OK = 2'h1;
  localparam logic [1:0] DN_ANS_ERR = 2'h2;
  localparam logic [1:0] DN_ABORT = 2'h3;
  // ==========================================================
  // Slave address and timing
  localparam logic [6:0] OWN_SLAVE_ADDR = 7'h52;
  localparam int MCLK_MHZ = 200;
  localparam int ANS_WAIT_US = 1000;
  localparam int ANS_WAIT_CYCLES = ANS_WAIT_US * MCLK_MHZ;

  typedef enum logic [2:0] {
    ST_IDLE, ST_RF, ST_TUN_RX, ST_WAIT_Q, ST_WAIT_A
  } rhx_state_e;

  typedef enum logic [2:0] {
    C_READ, C_WRITE, C_STATUS, C_REG_WR, C_REG_RD,
    C_QUERY, C_ANSWER, C_UNIMPL
  } rhx_cmd_e;

  function automatic rhx_cmd_e rhx_classify(input logic [7:0] c);
    case (c)
      CMD_READ: return C_READ;
      CMD_WRITE: return C_WRITE;
      CMD_STATUS: return C_STATUS;
      CMD_REG_WR: return C_REG_WR;
      CMD_REG_RD: return C_REG_RD;
      CMD_QUERY: return C_QUERY;
      CMD_ANS_OK, CMD_ANS_ERR: return C_ANSWER;
      default: return C_UNIMPL;
    endcase
  endfunction : rhx_classify

  // Register access result: diagnosis error overrides the given status
  function automatic logic [7:0] rhx_reg_result(input logic diag,
                                                input logic [7:0] ok);
    return diag ? ST_DIAG : ok;
  endfunction : rhx_reg_result
endpackage : rhx_pkg

// ### hdl/rhx_evt_sync.sv
// Event crossing between two clocks by toggle, with held data word
`timescale 1ns/1ps
`default_nettype none
module rhx_evt_sync #(
  parameter int W = 2
) (
  input wire logic src_clk,
  input wire logic src_rst,
  input wire logic src_ce,
  input wire logic src_fire,
  input wire logic [W-1:0] src_data,
  input wire logic dst_clk,
  input wire logic dst_rst,
  input wire logic dst_ce,
  output logic dst_fire,
  output logic [W-1:0] dst_data
);
  typedef struct packed {
    logic tog;
    logic [W-1:0] data;
  } rhx_src_s;
  typedef struct packed {
    logic [2:0] s;
    logic fire;
    logic [W-1:0] data;
  } rhx_dst_s;

  rhx_src_s src_ff, nxt_src;
  rhx_dst_s dst_ff, nxt_dst;

  // ==========================================================
  // Source side
  always_comb begin
    nxt_src = src_ff;
    if (src_fire) begin
      nxt_src.tog = ~src_ff.tog;
      nxt_src.data = src_data;
    end
  end

  always_ff @(posedge src_clk) begin
    if (src_rst) begin
      src_ff <= '0;
    end else if (src_ce) begin
      src_ff <= nxt_src;
    end
  end

  // ==========================================================
  // Destination side
  // Data word is stable well before the toggle is seen here, so
  // events must be spaced by at least four destination cycles.
  always_comb begin
    nxt_dst = dst_ff;
    nxt_dst.s = {dst_ff.s[1:0], src_ff.tog};
    nxt_dst.fire = dst_ff.s[2] ^ dst_ff.s[1];
    if (dst_ff.s[2] ^ dst_ff.s[1]) begin
      nxt_dst.data = src_ff.data;
    end
  end

  always_ff @(posedge dst_clk) begin
    if (dst_rst) begin
      dst_ff <= '0;
    end else if (dst_ce) begin
      dst_ff <= nxt_dst;
    end
  end

  assign dst_fire = dst_ff.fire;
  assign dst_data = dst_ff.data;
endmodule : rhx_evt_sync
`default_nettype wire

// ### hdl/rhx_excl_ctrl.sv
// Exclusive control between serial host and RF reader/writer
// Overview of operation
// - Refuse other commands during operation command
// - Tunnel exclusive until reply sent to reader
// - Answer only own address; unknown code errors
// - RF busy: BUSY, register normal, tunnel error
// - Serial transaction busy: reply host-collision busy
// - Query wait: status detect, query continues
// - Query wait: register access returns tunnel detect
// - Query wait: RF stop write ends normally
// - Answer wait: answer continues, others mapped
// - Exclusive period: JIS commands get no reply
// - Extension select 0: ISO gets no reply
// - Extension select 1: wait-extension for some
// - Host reply first, then tunnel detect interrupt
// - Later host commands raise no interrupt
// - Carrier loss returns tunnel states to idle
// - Non-answer host command restarts answer timer
// - Answer command returns to idle
`timescale 1ns/1ps
`default_nettype none
module rhx_excl_ctrl
  import rhx_pkg::*;
#(
  parameter int ANSWER_WAIT_CYCLES = ANS_WAIT_CYCLES
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic rf_clk,
  input wire logic rf_rst,
  input wire logic host_cmd_valid,
  input wire logic [6:0] host_slave_addr,
  input wire logic [7:0] host_cmd_code,
  input wire logic host_rf_stop,
  input wire logic reg_diag_err,
  input wire logic host_rsp_done,
  output logic host_rsp_valid,
  output logic [7:0] host_rsp_code,
  output logic tunnel_irq,
  output logic answer_wait_state,
  input wire logic rf_carrier,
  input wire logic wait_extension_select,
  input wire logic rf_cmd_valid,
  input wire logic rf_cmd_iso,
  input wire logic rf_cmd_wtx_class,
  input wire logic rf_cmd_tunnel,
  input wire logic rf_tunnel_write,
  input wire logic rf_resp_done,
  output logic rf_reply_valid,
  output logic [1:0] rf_reply_kind,
  output logic rf_reply_err
);
  localparam int AW = $clog2(ANSWER_WAIT_CYCLES + 1);

  typedef struct packed {
    rhx_state_e st;
    logic hbusy;
    logic rsp_valid;
    logic [7:0] rsp_code;
    logic irq;
    logic tun_wr;
    logic [AW-1:0] ans_cnt;
    logic [1:0] car_s;
    logic dn_fire;
    logic [1:0] dn_data;
  } rhx_host_s;

  typedef struct packed {
    logic rop;
    logic rtun;
    logic [1:0] hb_s;
    logic [1:0] wes_s;
    logic rpl_valid;
    logic [1:0] rpl_kind;
    logic rpl_err;
    logic up_fire;
    logic [2:0] up_data;
  } rhx_rf_s;

  rhx_host_s m_ff, nxt_m;
  rhx_rf_s r_ff, nxt_r;
  logic up_fire, dn_fire;
  logic [2:0] up_data;
  logic [1:0] dn_data;
  logic cmd_hit, tun_st;
  rhx_cmd_e cls;
  logic [7:0] tun_det;

  // ==========================================================
  // Crossings
  rhx_evt_sync #(.W(3)) u_up (
    .src_clk(rf_clk),
    .src_rst(rf_rst),
    .src_ce(1'b1),
    .src_fire(r_ff.up_fire),
    .src_data(r_ff.up_data),
    .dst_clk(mclk),
    .dst_rst(rst),
    .dst_ce(ce),
    .dst_fire(up_fire),
    .dst_data(up_data)
  );

  rhx_evt_sync #(.W(2)) u_dn (
    .src_clk(mclk),
    .src_rst(rst),
    .src_ce(ce),
    .src_fire(m_ff.dn_fire),
    .src_data(m_ff.dn_data),
    .dst_clk(rf_clk),
    .dst_rst(rf_rst),
    .dst_ce(1'b1),
    .dst_fire(dn_fire),
    .dst_data(dn_data)
  );

  // ==========================================================
  // Host side
  assign cmd_hit = host_cmd_valid && (host_slave_addr == OWN_SLAVE_ADDR);
  assign cls = rhx_classify(host_cmd_code);
  assign tun_st = (m_ff.st == ST_TUN_RX) || (m_ff.st == ST_WAIT_Q) ||
                  (m_ff.st == ST_WAIT_A);
  assign tun_det = m_ff.tun_wr ? ST_TUN_WR : ST_TUN_RD;

  always_comb begin
    nxt_m = m_ff;
    nxt_m.rsp_valid = 1'b0;
    nxt_m.dn_fire = 1'b0;
    nxt_m.car_s = {m_ff.car_s[0], rf_carrier};
    if (m_ff.hbusy && host_rsp_done) begin
      nxt_m.hbusy = 1'b0;
    end
    if (up_fire) begin
      case (up_data[1:0])
        EV_OP_START: if (m_ff.st == ST_IDLE) nxt_m.st = ST_RF;
        EV_OP_END: if (m_ff.st == ST_RF) nxt_m.st = ST_IDLE;
        EV_TUN: begin
          nxt_m.st = ST_TUN_RX;
          nxt_m.tun_wr = up_data[2];
        end
        default: ;
      endcase
    end
    // Interrupt held back while a host exchange is open
    if (m_ff.st == ST_TUN_RX && !m_ff.hbusy && !cmd_hit) begin
      nxt_m.st = ST_WAIT_Q;
      nxt_m.irq = 1'b1;
    end
    if (m_ff.st == ST_WAIT_A) begin
      if (m_ff.ans_cnt == '0) begin
        nxt_m.st = ST_IDLE;
        nxt_m.dn_fire = 1'b1;
        nxt_m.dn_data = DN_ABORT;
      end else begin
        nxt_m.ans_cnt = m_ff.ans_cnt - 1'b1;
      end
    end
    if (cmd_hit) begin
      nxt_m.rsp_valid = 1'b1;
      if (m_ff.hbusy) begin
        nxt_m.rsp_code = ST_HOST_BUSY;
      end else begin
        nxt_m.hbusy = 1'b1;
        nxt_m.rsp_code = ST_NORMAL;
        case (m_ff.st)
          ST_IDLE: begin
            case (cls)
              C_REG_WR, C_REG_RD:
                nxt_m.rsp_code = rhx_reg_result(reg_diag_err, ST_NORMAL);
              C_QUERY, C_ANSWER: nxt_m.rsp_code = ST_TUN_ERR;
              default: ;
            endcase
          end
          ST_RF, ST_TUN_RX: begin
            case (cls)
              C_READ, C_WRITE, C_STATUS: nxt_m.rsp_code = ST_BUSY;
              C_REG_WR, C_REG_RD:
                nxt_m.rsp_code = rhx_reg_result(reg_diag_err, ST_NORMAL);
              C_QUERY, C_ANSWER: nxt_m.rsp_code = ST_TUN_ERR;
              default: ;
            endcase
          end
          ST_WAIT_Q: begin
            case (cls)
              C_READ, C_WRITE, C_ANSWER: nxt_m.rsp_code = ST_UNIMPL;
              C_STATUS: nxt_m.rsp_code = tun_det;
              C_REG_WR, C_REG_RD: begin
                if (cls == C_REG_WR && host_rf_stop) begin
                  nxt_m.rsp_code =
                    rhx_reg_result(reg_diag_err, ST_NORMAL);
                end else begin
                  nxt_m.rsp_code =
                    rhx_reg_result(reg_diag_err, tun_det);
                end
              end
              C_QUERY: begin
                nxt_m.rsp_code = ST_QUERY_OK;
                nxt_m.st = ST_WAIT_A;
                nxt_m.irq = 1'b0;
                nxt_m.ans_cnt = AW'(ANSWER_WAIT_CYCLES);
              end
              default: ;
            endcase
          end
          ST_WAIT_A: begin
            nxt_m.ans_cnt = AW'(ANSWER_WAIT_CYCLES);
            case (cls)
              C_READ, C_WRITE, C_QUERY: nxt_m.rsp_code = ST_UNIMPL;
              C_STATUS: nxt_m.rsp_code = tun_det;
              C_REG_WR, C_REG_RD:
                nxt_m.rsp_code = rhx_reg_result(reg_diag_err, ST_NORMAL);
              C_ANSWER: begin
                nxt_m.st = ST_IDLE;
                nxt_m.dn_fire = 1'b1;
                nxt_m.dn_data = (host_cmd_code == CMD_ANS_OK) ?
                                DN_ANS_OK : DN_ANS_ERR;
              end
              default: ;
            endcase
          end
          default: ;
        endcase
        if (cls == C_UNIMPL) begin
          nxt_m.rsp_code = ST_UNIMPL;
        end
      end
    end
    // Carrier loss wins over any host command in the same cycle
    if (tun_st && !m_ff.car_s[1]) begin
      nxt_m.st = ST_IDLE;
      nxt_m.irq = 1'b0;
      nxt_m.dn_fire = 1'b1;
      nxt_m.dn_data = DN_ABORT;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      m_ff <= '0;
    end else if (ce) begin
      m_ff <= nxt_m;
    end
  end

  assign host_rsp_valid = m_ff.rsp_valid;
  assign host_rsp_code = m_ff.rsp_code;
  assign tunnel_irq = m_ff.irq;
  assign answer_wait_state = (m_ff.st == ST_WAIT_A);

  // ==========================================================
  // RF side
  always_comb begin
    nxt_r = r_ff;
    nxt_r.rpl_valid = 1'b0;
    nxt_r.up_fire = 1'b0;
    nxt_r.hb_s = {r_ff.hb_s[0], m_ff.hbusy};
    nxt_r.wes_s = {r_ff.wes_s[0], wait_extension_select};
    if (rf_cmd_valid) begin
      nxt_r.rpl_valid = 1'b1;
      nxt_r.rpl_kind = RPL_NONE;
      nxt_r.rpl_err = 1'b0;
      if (r_ff.rop || r_ff.rtun) begin
        nxt_r.rpl_kind = RPL_NONE;
      end else if (r_ff.hb_s[1]) begin
        if (rf_cmd_iso && r_ff.wes_s[1]) begin
          nxt_r.rpl_kind = rf_cmd_wtx_class ? RPL_WTX : RPL_NORMAL;
        end
      end else if (rf_cmd_tunnel) begin
        nxt_r.rtun = 1'b1;
        nxt_r.rpl_valid = 1'b0;
        nxt_r.up_fire = 1'b1;
        nxt_r.up_data = {rf_tunnel_write, EV_TUN};
      end else begin
        nxt_r.rop = 1'b1;
        nxt_r.rpl_kind = RPL_NORMAL;
        nxt_r.up_fire = 1'b1;
        nxt_r.up_data = {1'b0, EV_OP_START};
      end
    end
    if (rf_resp_done) begin
      // Exclusive period ends only once the reply has left
      if (r_ff.rop) begin
        nxt_r.rop = 1'b0;
        nxt_r.up_fire = 1'b1;
        nxt_r.up_data = {1'b0, EV_OP_END};
      end
      nxt_r.rtun = 1'b0;
    end
    if (dn_fire) begin
      if (dn_data == DN_ABORT) begin
        nxt_r.rtun = 1'b0;
      end else begin
        nxt_r.rpl_valid = 1'b1;
        nxt_r.rpl_kind = RPL_TUNNEL;
        nxt_r.rpl_err = (dn_data == DN_ANS_ERR);
      end
    end
  end

  always_ff @(posedge rf_clk) begin
    if (rf_rst) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign rf_reply_valid = r_ff.rpl_valid;
  assign rf_reply_kind = r_ff.rpl_kind;
  assign rf_reply_err = r_ff.rpl_err;

  // ==========================================================
  // Checks
  sequence hit_free_s;
    ce && cmd_hit && !m_ff.hbusy;
  endsequence
  sequence hit_busy_s;
    ce && cmd_hit && m_ff.hbusy;
  endsequence

  host_busy_a: assert property (@(posedge mclk) disable iff (rst)
    hit_busy_s |=> host_rsp_valid && host_rsp_code == ST_HOST_BUSY)
    else $error("host collision not answered with host busy");
  unimpl_code_a: assert property (@(posedge mclk) disable iff (rst)
    hit_free_s ##0 (cls == C_UNIMPL) |=> host_rsp_code == ST_UNIMPL)
    else $error("unknown command not answered as unimplemented");
  rf_busy_a: assert property (@(posedge mclk) disable iff (rst)
    hit_free_s ##0 (m_ff.st == ST_RF && cls == C_READ)
    |=> host_rsp_code == ST_BUSY)
    else $error("read during RF activity not answered busy");
  irq_defer_a: assert property (@(posedge mclk) disable iff (rst)
    ce && m_ff.st == ST_TUN_RX && m_ff.hbusy |=> !tunnel_irq)
    else $error("tunnel interrupt raised before host reply");
  query_step_a: assert property (@(posedge mclk) disable iff (rst)
    hit_free_s ##0 (m_ff.st == ST_WAIT_Q && cls == C_QUERY)
    ##0 m_ff.car_s[1] |=> answer_wait_state && !tunnel_irq)
    else $error("query did not enter answer wait");
  answer_idle_a: assert property (@(posedge mclk) disable iff (rst)
    hit_free_s ##0 (m_ff.st == ST_WAIT_A && cls == C_ANSWER)
    |=> m_ff.st == ST_IDLE ##1 !answer_wait_state)
    else $error("answer did not return to idle");
  timer_reload_a: assert property (@(posedge mclk) disable iff (rst)
    hit_free_s ##0 (m_ff.st == ST_WAIT_A && cls != C_ANSWER)
    ##0 m_ff.car_s[1] |=> m_ff.ans_cnt == AW'(ANSWER_WAIT_CYCLES))
    else $error("answer wait timer not restarted");
  carrier_idle_a: assert property (@(posedge mclk) disable iff (rst)
    ce && tun_st && !m_ff.car_s[1] |=> m_ff.st == ST_IDLE && !tunnel_irq)
    else $error("carrier loss did not return to idle");
  rf_excl_a: assert property (@(posedge rf_clk) disable iff (rf_rst)
    rf_cmd_valid && r_ff.rop && !rf_resp_done && !dn_fire
    |=> rf_reply_kind == RPL_NONE && r_ff.rop)
    else $error("RF command served during RF operation");
  jis_silent_a: assert property (@(posedge rf_clk) disable iff (rf_rst)
    rf_cmd_valid && r_ff.hb_s[1] && !rf_cmd_iso && !dn_fire
    |=> rf_reply_valid && rf_reply_kind == RPL_NONE)
    else $error("JIS command answered in exclusive period");
  wtx_reply_a: assert property (@(posedge rf_clk) disable iff (rf_rst)
    rf_cmd_valid && !r_ff.rop && !r_ff.rtun && r_ff.hb_s[1] && rf_cmd_iso
    && r_ff.wes_s[1] && rf_cmd_wtx_class && !dn_fire
    |=> rf_reply_kind == RPL_WTX)
    else $error("wait extension frame missing");
endmodule : rhx_excl_ctrl
`default_nettype wire

// ### test/rhx_rf_model.sv
// Behavioural RF reader/writer engine facing the exclusive control block
`timescale 1ns/1ps
`default_nettype none
module rhx_rf_model (
  input wire logic rf_clk,
  input wire logic auto_done,
  input wire logic rf_reply_valid,
  input wire logic [1:0] rf_reply_kind,
  output logic rf_cmd_valid,
  output logic rf_cmd_iso,
  output logic rf_cmd_wtx_class,
  output logic rf_cmd_tunnel,
  output logic rf_tunnel_write,
  output logic rf_resp_done
);
  logic pend;
  initial begin
    {rf_cmd_valid, rf_cmd_iso, rf_cmd_wtx_class} = 3'h0;
    {rf_cmd_tunnel, rf_tunnel_write, rf_resp_done, pend} = 4'h0;
  end
  // ==========================================================
  // Command issue; f = {iso, wtx_class, tunnel, write}
  task automatic send(input logic [3:0] f, output logic [1:0] kind);
    @(posedge rf_clk);
    rf_cmd_valid <= 1'b1;
    {rf_cmd_iso, rf_cmd_wtx_class, rf_cmd_tunnel, rf_tunnel_write} <= f;
    @(posedge rf_clk);
    rf_cmd_valid <= 1'b0;
    // Stale qualifiers flip so they never look valid by accident
    {rf_cmd_iso, rf_cmd_wtx_class, rf_cmd_tunnel, rf_tunnel_write} <= ~f;
    kind = 2'h0;
    repeat (3) begin
      #1;
      if (rf_reply_valid === 1'b1) kind = rf_reply_kind;
      @(posedge rf_clk);
    end
  endtask : send
  // ==========================================================
  // Response transmission ends later; held back while auto_done is low
  always @(posedge rf_clk) begin
    rf_resp_done <= 1'b0;
    if (rf_reply_valid && rf_reply_kind inside {2'h1, 2'h3}) begin
      pend <= 1'b1;
    end else if (pend && auto_done) begin
      pend <= 1'b0;
      rf_resp_done <= 1'b1;
    end
  end
endmodule : rhx_rf_model
`default_nettype wire

// ### test/tb.sv
// Self-checking bench of the exclusive control block
`timescale 1ns/1ps
`default_nettype none
module tb
  import rhx_pkg::*;
;
  localparam int ANS_WAIT = 50;
  logic mclk, rst, ce, rf_clk, rf_rst, auto_done, rf_carrier;
  logic host_cmd_valid, host_rf_stop, reg_diag_err, host_rsp_done;
  logic [6:0] host_slave_addr;
  logic [7:0] host_cmd_code, host_rsp_code, r, n3;
  logic host_rsp_valid, tunnel_irq, answer_wait_state, wait_extension_select;
  logic rf_cmd_valid, rf_cmd_iso, rf_cmd_wtx_class, rf_cmd_tunnel;
  logic rf_tunnel_write, rf_resp_done, rf_reply_valid, rf_reply_err;
  logic [1:0] rf_reply_kind;
  logic [7:0] tun_cnt = 8'h00;
  logic tun_err = 1'b0;
  int n_errors = 0;
  int checks = 0;
  int cyc = 0;

  rhx_excl_ctrl #(.ANSWER_WAIT_CYCLES(ANS_WAIT)) rhx_excl_ctrl_i (
    .mclk(mclk), .rst(rst), .ce(ce), .rf_clk(rf_clk), .rf_rst(rf_rst),
    .host_cmd_valid(host_cmd_valid), .host_slave_addr(host_slave_addr),
    .host_cmd_code(host_cmd_code), .host_rf_stop(host_rf_stop),
    .reg_diag_err(reg_diag_err), .host_rsp_done(host_rsp_done),
    .host_rsp_valid(host_rsp_valid), .host_rsp_code(host_rsp_code),
    .tunnel_irq(tunnel_irq), .answer_wait_state(answer_wait_state),
    .rf_carrier(rf_carrier), .wait_extension_select(wait_extension_select),
    .rf_cmd_valid(rf_cmd_valid), .rf_cmd_iso(rf_cmd_iso),
    .rf_cmd_wtx_class(rf_cmd_wtx_class), .rf_cmd_tunnel(rf_cmd_tunnel),
    .rf_tunnel_write(rf_tunnel_write), .rf_resp_done(rf_resp_done),
    .rf_reply_valid(rf_reply_valid), .rf_reply_kind(rf_reply_kind),
    .rf_reply_err(rf_reply_err)
  );
  rhx_rf_model rhx_rf_model_i (
    .rf_clk(rf_clk), .auto_done(auto_done), .rf_reply_valid(rf_reply_valid),
    .rf_reply_kind(rf_reply_kind), .rf_cmd_valid(rf_cmd_valid),
    .rf_cmd_iso(rf_cmd_iso), .rf_cmd_wtx_class(rf_cmd_wtx_class),
    .rf_cmd_tunnel(rf_cmd_tunnel), .rf_tunnel_write(rf_tunnel_write),
    .rf_resp_done(rf_resp_done)
  );
  // ==========================================================
  // Clocks; link clock offset so edges never coincide
  initial mclk = 1'b0;
  always #2.5 mclk = ~mclk;
  initial begin
    rf_clk = 1'b0;
    #7.3;
    forever #40 rf_clk = ~rf_clk;
  end
  always @(posedge rf_clk) begin
    if (rf_reply_valid === 1'b1 && rf_reply_kind === RPL_TUNNEL) begin
      tun_cnt <= tun_cnt + 8'h01;
      tun_err <= rf_reply_err;
    end
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      wrap_up();
    end
  end
  // ==========================================================
  // Shared helpers
  task automatic wrap_up();
    if (n_errors == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up
  task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", w, e, g);
    end
  endtask : chk
  task automatic chk1(input string w, input logic e, input logic g);
    #1;
    chk(w, {7'h00, e}, {7'h00, g});
  endtask : chk1
  // f = {rf_stop, diag, send final byte}; FF means no response seen
  task automatic hc(input logic [6:0] a, input logic [7:0] c,
                    input logic [2:0] f, output logic [7:0] rs);
    @(posedge mclk);
    host_cmd_valid <= 1'b1;
    host_slave_addr <= a;
    host_cmd_code <= c;
    {host_rf_stop, reg_diag_err} <= f[2:1];
    @(posedge mclk);
    host_cmd_valid <= 1'b0;
    rs = 8'hFF;
    repeat (3) begin
      #1;
      if (host_rsp_valid === 1'b1) rs = host_rsp_code;
      @(posedge mclk);
    end
    if (f[0]) begin
      host_rsp_done <= 1'b1;
      @(posedge mclk);
      host_rsp_done <= 1'b0;
    end
  endtask : hc
  task automatic ex(input logic [7:0] c, input logic [2:0] f,
                    input logic [7:0] e);
    logic [7:0] rs;
    hc(OWN_SLAVE_ADDR, c, f, rs);
    chk("host_rsp_code", e, rs);
  endtask : ex
  task automatic rx(input logic [3:0] f, input logic [1:0] e);
    logic [1:0] k;
    rhx_rf_model_i.send(f, k);
    chk("rf_reply_kind", {6'h00, e}, {6'h00, k});
  endtask : rx
  task automatic wirq(input logic e);
    #1;
    for (int n = 0; n < 40 && tunnel_irq !== e; n++) begin
      @(posedge mclk);
      #1;
    end
    chk1("tunnel_irq", e, tunnel_irq);
  endtask : wirq
  // ==========================================================
  // Scenarios
  task automatic t_basic();
    hc(7'h13, CMD_READ, 3'b000, r);
    chk("foreign_addr", 8'hFF, r);
    // Enable low: the command must not be taken at all
    ce <= 1'b0;
    hc(OWN_SLAVE_ADDR, CMD_READ, 3'b000, r);
    ce <= 1'b1;
    chk("frozen_rsp", 8'hFF, r);
    ex(8'h55, 3'b001, ST_UNIMPL);
    ex(CMD_READ, 3'b000, ST_NORMAL);
    ex(CMD_REG_WR, 3'b000, ST_HOST_BUSY);
    ex(CMD_QUERY, 3'b001, ST_HOST_BUSY);
    ex(CMD_REG_RD, 3'b011, ST_DIAG);
  endtask : t_basic
  task automatic t_rf();
    auto_done <= 1'b0;
    rx(4'b0000, RPL_NORMAL);
    repeat (8) @(posedge mclk);
    ex(CMD_READ, 3'b001, ST_BUSY);
    ex(CMD_STATUS, 3'b001, ST_BUSY);
    ex(CMD_REG_WR, 3'b011, ST_DIAG);
    ex(CMD_ANS_OK, 3'b001, ST_TUN_ERR);
    rx(4'b0000, RPL_NONE);
    auto_done <= 1'b1;
    repeat (6) @(posedge rf_clk);
    ex(CMD_READ, 3'b001, ST_NORMAL);
  endtask : t_rf
  task automatic t_hbusy();
    ex(CMD_READ, 3'b000, ST_NORMAL);
    repeat (4) @(posedge rf_clk);
    rx(4'b0000, RPL_NONE);
    rx(4'b1100, RPL_NONE);
    wait_extension_select <= 1'b1;
    repeat (4) @(posedge rf_clk);
    rx(4'b1100, RPL_WTX);
    rx(4'b1000, RPL_NORMAL);
    wait_extension_select <= 1'b0;
    ex(CMD_STATUS, 3'b001, ST_HOST_BUSY);
    repeat (6) @(posedge rf_clk);
  endtask : t_hbusy
  task automatic t_tunnel();
    rx(4'b0011, RPL_NONE);
    wirq(1'b1);
    ex(CMD_STATUS, 3'b001, ST_TUN_WR);
    ex(CMD_READ, 3'b001, ST_UNIMPL);
    ex(CMD_ANS_OK, 3'b001, ST_UNIMPL);
    ex(CMD_REG_RD, 3'b001, ST_TUN_WR);
    ex(CMD_REG_WR, 3'b011, ST_DIAG);
    ex(CMD_REG_WR, 3'b101, ST_NORMAL);
    rx(4'b1000, RPL_NONE);
    ex(CMD_QUERY, 3'b001, ST_QUERY_OK);
    chk1("answer_wait_state", 1'b1, answer_wait_state);
    ex(CMD_QUERY, 3'b001, ST_UNIMPL);
    ex(CMD_STATUS, 3'b001, ST_TUN_WR);
    ex(CMD_REG_WR, 3'b001, ST_NORMAL);
    n3 = tun_cnt;
    ex(CMD_ANS_ERR, 3'b001, ST_NORMAL);
    chk1("answer_wait_state", 1'b0, answer_wait_state);
    repeat (8) @(posedge rf_clk);
    chk("tunnel_replies", n3 + 8'h01, tun_cnt);
    chk1("rf_reply_err", 1'b1, tun_err);
  endtask : t_tunnel
  task automatic t_timer();
    rx(4'b0010, RPL_NONE);
    wirq(1'b1);
    ex(CMD_STATUS, 3'b001, ST_TUN_RD);
    ex(CMD_QUERY, 3'b001, ST_QUERY_OK);
    wirq(1'b0);
    repeat (4) begin
      repeat (ANS_WAIT - 20) @(posedge mclk);
      ex(CMD_READ, 3'b001, ST_UNIMPL);
    end
    chk1("answer_wait_state", 1'b1, answer_wait_state);
    repeat (ANS_WAIT + 10) @(posedge mclk);
    chk1("answer_wait_state", 1'b0, answer_wait_state);
    repeat (8) @(posedge rf_clk);
  endtask : t_timer
  task automatic t_order();
    fork
      rx(4'b0011, RPL_NONE);
      begin
        @(negedge rf_cmd_valid);
        hc(OWN_SLAVE_ADDR, CMD_READ, 3'b000, r);
      end
    join
    chk("host_answered", 8'h01, {7'h00, r !== 8'hFF});
    repeat (20) @(posedge mclk);
    chk1("tunnel_irq", 1'b0, tunnel_irq);
    ex(CMD_STATUS, 3'b001, ST_HOST_BUSY);
    wirq(1'b1);
    ex(CMD_QUERY, 3'b001, ST_QUERY_OK);
    ex(CMD_ANS_OK, 3'b001, ST_NORMAL);
    repeat (8) @(posedge rf_clk);
    chk1("rf_reply_err", 1'b0, tun_err);
  endtask : t_order
  task automatic t_carrier();
    rx(4'b0011, RPL_NONE);
    wirq(1'b1);
    // Carrier loss while the interrupt is up, waiting for query
    rf_carrier <= 1'b0;
    wirq(1'b0);
    @(posedge mclk);
    rf_carrier <= 1'b1;
    repeat (8) @(posedge rf_clk);
    rx(4'b0011, RPL_NONE);
    wirq(1'b1);
    ex(CMD_QUERY, 3'b001, ST_QUERY_OK);
    // Pin passes two flops before the state can drop
    rf_carrier <= 1'b0;
    repeat (4) @(posedge mclk);
    chk1("answer_wait_state", 1'b0, answer_wait_state);
    @(posedge mclk);
    rf_carrier <= 1'b1;
    ex(CMD_READ, 3'b001, ST_NORMAL);
  endtask : t_carrier
  // ==========================================================
  // Main sequence
  initial begin
    {rst, rf_rst, ce, auto_done, rf_carrier} = 5'h1F;
    {host_cmd_valid, host_rf_stop, reg_diag_err, host_rsp_done} = 4'h0;
    wait_extension_select = 1'b0;
    host_slave_addr = OWN_SLAVE_ADDR;
    host_cmd_code = 8'h00;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    repeat (6) @(posedge rf_clk);
    rf_rst <= 1'b0;
    repeat (4) @(posedge rf_clk);
    chk("reset_rsp_code", 8'h00, host_rsp_code);
    t_basic();
    t_rf();
    t_hbusy();
    t_tunnel();
    t_timer();
    t_order();
    t_carrier();
    wrap_up();
  end
endmodule : tb
`default_nettype wire
